// ==== reset_seq_pkg.sv ====
package reset_seq_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned POWERUP_DELAY_TIME_MS = 72;
	localparam int unsigned RC_OSC_HZ = 100_000;
	localparam int unsigned POWERUP_TIMER_TICKS_DEFAULT = POWERUP_DELAY_TIME_MS * RC_OSC_HZ / 1000;
	localparam int unsigned BROWNOUT_MIN_DURATION_US = 100;
	localparam int unsigned BOR_FILTER_CYCLES_DEFAULT =
		(BROWNOUT_MIN_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OST_CYCLES_DEFAULT = 1024;
	localparam int unsigned MASTER_CLEAR_N_FILTER_CYCLES_DEFAULT = 16;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] CONFIG_WORD_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] POWER_STATUS_ADDR = 8'h08;
	localparam logic [7:0] RETAINED_ADDR = 8'h0c;
	localparam logic [7:0] SCRATCH_ADDR = 8'h10;

	localparam logic [13:0] CFG_RESET = 14'h3fff;
	localparam int unsigned CFG_BOREN_BIT = 6;
	localparam int unsigned CFG_POWERUP_DELAY_ENABLE_N_N_BIT = 3;
	localparam int unsigned CFG_OSC_LSB = 0;
	localparam logic [1:0] OSC_RC = 2'h3;
	localparam logic [1:0] OSC_HS = 2'h2;
	localparam logic [1:0] OSC_XT = 2'h1;
	localparam logic [1:0] OSC_LP = 2'h0;

	localparam int unsigned STAT_TO_BIT = 0;
	localparam int unsigned STAT_PD_BIT = 1;
	localparam int unsigned STAT_CAUSE_LSB = 2;
	localparam int unsigned STAT_RESET_BIT = 5;
	localparam int unsigned STAT_HOLD_BIT = 6;
	localparam int unsigned PSTAT_BOR_BIT = 0;
	localparam int unsigned PSTAT_POR_BIT = 1;

	localparam logic TO_RESET = 1'b1;
	localparam logic PD_RESET = 1'b1;
	localparam logic POR_STAT_RESET = 1'b0;
	localparam logic BOR_STAT_RESET = 1'b1;
	localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		CAUSE_NONE,
		CAUSE_POWER_ON,
		CAUSE_MASTER_CLEAR_N_RUN,
		CAUSE_MASTER_CLEAR_N_SLEEP,
		CAUSE_WDT_RESET,
		CAUSE_WDT_WAKE,
		CAUSE_BROWNOUT
	} reset_cause_t;

	typedef enum logic [2:0] {
		SEQ_WAIT_SUPPLY,
		SEQ_BOR_HOLD,
		SEQ_POWERUP_TIMER,
		SEQ_OST,
		SEQ_RUN
	} seq_state_t;
endpackage : reset_seq_pkg

// ==== filt_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface filt_if;
	logic level;
	logic rose;
	logic fell;
	modport src (output level, output rose, output fell);
	modport dst (input level, input rose, input fell);
endinterface : filt_if
`default_nettype wire

// ==== level_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
module level_filter #(
	parameter int unsigned RISE_CYCLES = 1,
	parameter int unsigned FALL_CYCLES = 1,
	parameter logic INIT = 1'b0
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// raw asynchronous input
	input wire logic raw,
	// filtered level and edges
	filt_if.src out
);
	localparam int unsigned MAXC = (RISE_CYCLES > FALL_CYCLES) ? RISE_CYCLES : FALL_CYCLES;
	localparam int unsigned CNT_W = $clog2(MAXC + 1);

	logic s1_q, s2_q, s3_q, level_q, rose_q, fell_q;
	logic [CNT_W-1:0] cnt_q;
	logic agree, differ, flip;
	logic [CNT_W-1:0] need;

	// a change only counts while the second and third stages agree
	assign agree = (s2_q == s3_q);
	assign differ = agree && (s3_q != level_q);
	assign need = level_q ? CNT_W'(FALL_CYCLES - 1) : CNT_W'(RISE_CYCLES - 1);
	assign flip = differ && (cnt_q == need);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// any glitch back to the old level restarts the count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
			level_q <= INIT;
			rose_q <= 1'b0;
			fell_q <= 1'b0;
		end else begin
			cnt_q <= (!differ || flip) ? '0 : cnt_q + 1'b1;
			level_q <= flip ? !level_q : level_q;
			rose_q <= flip && !level_q;
			fell_q <= flip && level_q;
		end
	end

	assign out.level = level_q;
	assign out.rose = rose_q;
	assign out.fell = fell_q;

	property p_filter_hold;
		@(posedge hclk) disable iff (!hresetn)
		(s2_q != s3_q) |=> $stable(level_q);
	endproperty
	a_filter_hold: assert property (p_filter_hold)
		else $error("filtered level moved while sync stages disagreed");

	property p_filter_len;
		@(posedge hclk) disable iff (!hresetn)
		$changed(level_q) |-> ($past(cnt_q) == $past(need));
	endproperty
	a_filter_len: assert property (p_filter_len)
		else $error("filtered level moved before the stable count");
endmodule : level_filter
`default_nettype wire

// ==== reset_timeout_sequencer.sv ====
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module reset_timeout_sequencer
	import reset_seq_pkg::*;
#(
	parameter int unsigned MASTER_CLEAR_N_FILTER_CYCLES = reset_seq_pkg::MASTER_CLEAR_N_FILTER_CYCLES_DEFAULT,
	parameter int unsigned BOR_FILTER_CYCLES = reset_seq_pkg::BOR_FILTER_CYCLES_DEFAULT,
	parameter int unsigned POWERUP_TIMER_TICKS = reset_seq_pkg::POWERUP_TIMER_TICKS_DEFAULT,
	parameter int unsigned OST_CYCLES = reset_seq_pkg::OST_CYCLES_DEFAULT
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// supply monitor and pins
	input wire logic supply_rise_det,
	input wire logic brownout_detect,
	input wire logic master_clear_n,
	input wire logic osc_input_pin,
	input wire logic rc_osc_clk,
	// core side
	input wire logic cpu_asleep,
	input wire logic watchdog_timeout,
	input wire logic watchdog_clear,
	input wire logic sleep_cmd,
	output logic core_reset_n,
	output logic core_hold,
	output logic watchdog_wake
);
	import reset_seq_pkg::*;

	localparam int unsigned POWERUP_TIMER_W = $clog2(POWERUP_TIMER_TICKS + 1);
	localparam int unsigned OST_W = $clog2(OST_CYCLES + 1);

	// ************************************************************
	// input conditioning
	// ************************************************************
	// pins are sampled on hclk, so the oscillator and rc inputs must stay
	// well below a quarter of hclk; a faster crystal needs a prescaler
	filt_if supply_f ();
	filt_if bor_f ();
	filt_if master_clear_n_f ();
	filt_if osc_f ();
	filt_if rc_f ();

	level_filter #(.RISE_CYCLES(1), .FALL_CYCLES(1), .INIT(1'b0)) u_supply (
		.hclk(hclk), .hresetn(hresetn), .raw(supply_rise_det), .out(supply_f)
	);
	level_filter #(.RISE_CYCLES(BOR_FILTER_CYCLES), .FALL_CYCLES(1), .INIT(1'b0)) u_bor (
		.hclk(hclk), .hresetn(hresetn), .raw(brownout_detect), .out(bor_f)
	);
	level_filter #(
		.RISE_CYCLES(MASTER_CLEAR_N_FILTER_CYCLES), .FALL_CYCLES(MASTER_CLEAR_N_FILTER_CYCLES), .INIT(1'b1)
	) u_master_clear_n (
		.hclk(hclk), .hresetn(hresetn), .raw(master_clear_n), .out(master_clear_n_f)
	);
	level_filter #(.RISE_CYCLES(1), .FALL_CYCLES(1), .INIT(1'b0)) u_osc (
		.hclk(hclk), .hresetn(hresetn), .raw(osc_input_pin), .out(osc_f)
	);
	level_filter #(.RISE_CYCLES(1), .FALL_CYCLES(1), .INIT(1'b0)) u_rc (
		.hclk(hclk), .hresetn(hresetn), .raw(rc_osc_clk), .out(rc_f)
	);

	// ************************************************************
	// configuration decode
	// ************************************************************
	logic [13:0] cfg_q;
	logic boren, powerup_delay_enable_n_n, powerup_timer_on, crystal;
	logic [1:0] osc_mode_select;
	assign boren = cfg_q[CFG_BOREN_BIT];
	assign powerup_delay_enable_n_n = cfg_q[CFG_POWERUP_DELAY_ENABLE_N_N_BIT];
	assign osc_mode_select = cfg_q[CFG_OSC_LSB +: 2];
	assign powerup_timer_on = !powerup_delay_enable_n_n || boren;
	assign crystal = (osc_mode_select == OSC_LP) || (osc_mode_select == OSC_XT)
		|| (osc_mode_select == OSC_HS);

	// ************************************************************
	// reset events
	// ************************************************************
	seq_state_t state_q, state_d;
	logic wake_q, from_por_q;
	logic por_evt, bor_low, bor_evt, master_clear_n_low, master_clear_n_evt;
	logic wdt_rst_evt, wdt_wake_evt, ost_wake;
	logic powerup_timer_done, ost_done, in_reset_d;
	logic [POWERUP_TIMER_W-1:0] powerup_timer_cnt_q;
	logic [OST_W-1:0] ost_cnt_q;

	assign por_evt = supply_f.rose;
	assign bor_low = boren && bor_f.level;
	assign bor_evt = bor_low && !por_evt && (state_q != SEQ_BOR_HOLD)
		&& (state_q != SEQ_WAIT_SUPPLY);
	assign master_clear_n_low = !master_clear_n_f.level;
	assign master_clear_n_evt = master_clear_n_f.fell;
	assign wdt_rst_evt = watchdog_timeout && !cpu_asleep && (state_q == SEQ_RUN);
	assign wdt_wake_evt = watchdog_timeout && cpu_asleep && (state_q == SEQ_RUN);
	assign ost_wake = wdt_wake_evt && crystal && !master_clear_n_low;
	assign powerup_timer_done = (state_q == SEQ_POWERUP_TIMER) && rc_f.rose
		&& (powerup_timer_cnt_q == POWERUP_TIMER_W'(POWERUP_TIMER_TICKS - 1));
	assign ost_done = (state_q == SEQ_OST) && osc_f.rose
		&& (ost_cnt_q == OST_W'(OST_CYCLES - 1));

	// ************************************************************
	// time-out sequence
	// ************************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			SEQ_WAIT_SUPPLY: state_d = SEQ_WAIT_SUPPLY;
			SEQ_BOR_HOLD: if (!bor_low) state_d = SEQ_POWERUP_TIMER;
			SEQ_POWERUP_TIMER: if (powerup_timer_done) begin
				state_d = (from_por_q && crystal) ? SEQ_OST : SEQ_RUN;
			end
			SEQ_OST: if (ost_done) state_d = SEQ_RUN;
			SEQ_RUN: if (ost_wake) state_d = SEQ_OST;
			default: state_d = SEQ_WAIT_SUPPLY;
		endcase
		if (bor_evt) state_d = SEQ_BOR_HOLD;
		if (por_evt) begin
			state_d = powerup_timer_on ? SEQ_POWERUP_TIMER : (crystal ? SEQ_OST : SEQ_RUN);
		end
	end

	// the watchdog only reaches the internal core reset; the clear pin is
	// an input here and nothing can pull it
	assign in_reset_d = ((state_d != SEQ_RUN) && !(state_d == SEQ_OST && (wake_q || ost_wake)
		&& !bor_evt && !por_evt)) || master_clear_n_low || wdt_rst_evt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= SEQ_WAIT_SUPPLY;
			wake_q <= 1'b0;
			from_por_q <= 1'b0;
		end else begin
			state_q <= state_d;
			wake_q <= ost_wake || (wake_q && (state_d == SEQ_OST) && !bor_evt && !por_evt);
			from_por_q <= por_evt || (from_por_q && !bor_evt);
		end
	end

	// counters restart whenever their stage is entered afresh
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			powerup_timer_cnt_q <= '0;
			ost_cnt_q <= '0;
		end else begin
			if (state_q != SEQ_POWERUP_TIMER || por_evt || bor_evt || powerup_timer_done) begin
				powerup_timer_cnt_q <= '0;
			end else if (rc_f.rose) begin
				powerup_timer_cnt_q <= powerup_timer_cnt_q + 1'b1;
			end
			if (state_q != SEQ_OST || por_evt || bor_evt || ost_done) begin
				ost_cnt_q <= '0;
			end else if (osc_f.rose) begin
				ost_cnt_q <= ost_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_reset_n <= 1'b0;
			core_hold <= 1'b1;
			watchdog_wake <= 1'b0;
		end else begin
			core_reset_n <= !in_reset_d;
			core_hold <= in_reset_d || (state_d != SEQ_RUN);
			watchdog_wake <= wdt_wake_evt;
		end
	end

	// ************************************************************
	// cause and status flags
	// ************************************************************
	reset_cause_t cause_q;
	logic timeout_flag_q, powerdown_flag_q, por_stat_q, bor_stat_q;
	logic wr_q, rd_take, take;
	logic [7:0] waddr_q;
	logic whi_q;

	function automatic logic hit(input logic [7:0] a, input logic hi, input logic [7:0] off);
		hit = hi && (a == off);
	endfunction : hit

	logic wr_cfg, wr_pstat, wr_keep, wr_scr;
	assign wr_cfg = wr_q && hit(waddr_q, whi_q, CONFIG_WORD_ADDR);
	assign wr_pstat = wr_q && hit(waddr_q, whi_q, POWER_STATUS_ADDR);
	assign wr_keep = wr_q && hit(waddr_q, whi_q, RETAINED_ADDR);
	assign wr_scr = wr_q && hit(waddr_q, whi_q, SCRATCH_ADDR);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_q <= CAUSE_NONE;
			timeout_flag_q <= TO_RESET;
			powerdown_flag_q <= PD_RESET;
		end else if (por_evt) begin
			cause_q <= CAUSE_POWER_ON;
			timeout_flag_q <= 1'b1;
			powerdown_flag_q <= 1'b1;
		end else if (bor_evt) begin
			cause_q <= CAUSE_BROWNOUT;
			timeout_flag_q <= 1'b1;
			powerdown_flag_q <= 1'b1;
		end else if (master_clear_n_evt) begin
			cause_q <= cpu_asleep ? CAUSE_MASTER_CLEAR_N_SLEEP : CAUSE_MASTER_CLEAR_N_RUN;
			timeout_flag_q <= cpu_asleep ? 1'b1 : timeout_flag_q;
			powerdown_flag_q <= cpu_asleep ? 1'b0 : powerdown_flag_q;
		end else if (wdt_rst_evt) begin
			cause_q <= CAUSE_WDT_RESET;
			timeout_flag_q <= 1'b0;
			powerdown_flag_q <= 1'b1;
		end else if (wdt_wake_evt) begin
			cause_q <= CAUSE_WDT_WAKE;
			timeout_flag_q <= 1'b0;
			powerdown_flag_q <= 1'b0;
		end else if (watchdog_clear) begin
			timeout_flag_q <= 1'b1;
			powerdown_flag_q <= 1'b1;
		end else if (sleep_cmd) begin
			timeout_flag_q <= 1'b1;
			powerdown_flag_q <= 1'b0;
		end
	end

	// the hardware clear beats a software set in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			por_stat_q <= POR_STAT_RESET;
			bor_stat_q <= BOR_STAT_RESET;
		end else begin
			if (por_evt) begin
				por_stat_q <= 1'b0;
			end else if (wr_pstat && hwdata[PSTAT_POR_BIT]) begin
				por_stat_q <= 1'b1;
			end
			if (bor_evt) begin
				bor_stat_q <= 1'b0;
			end else if (wr_pstat && hwdata[PSTAT_BOR_BIT]) begin
				bor_stat_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// registers and ahb-lite slave
	// ************************************************************
	logic [31:0] keep_q, scratch_q, rd_word, status_word, pstat_word;
	logic hi_zero;

	// no reset: contents survive every reset and are unknown after power-up
	always_ff @(posedge hclk) begin
		if (wr_keep) keep_q <= hwdata;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scratch_q <= SCRATCH_RESET;
			cfg_q <= CFG_RESET;
		end else begin
			if (!core_reset_n) begin
				scratch_q <= SCRATCH_RESET;
			end else if (wr_scr) begin
				scratch_q <= hwdata;
			end
			if (wr_cfg) cfg_q <= hwdata[13:0];
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STAT_TO_BIT] = timeout_flag_q;
		status_word[STAT_PD_BIT] = powerdown_flag_q;
		status_word[STAT_CAUSE_LSB +: 3] = cause_q;
		status_word[STAT_RESET_BIT] = !core_reset_n;
		status_word[STAT_HOLD_BIT] = core_hold;
		pstat_word = 32'h0000_0000;
		pstat_word[PSTAT_POR_BIT] = por_stat_q;
		pstat_word[PSTAT_BOR_BIT] = bor_stat_q;
	end

	// word transfers only; other sizes are ignored and leave hrdata unchanged; unmapped addresses read zero
	assign take = hsel && hready && htrans[1] && (hsize == 3'h2);
	assign rd_take = take && !hwrite;
	assign hi_zero = (haddr[31:8] == 24'h00_0000);
	assign rd_word = hit(haddr[7:0], hi_zero, CONFIG_WORD_ADDR) ? {18'h0_0000, cfg_q}
		: hit(haddr[7:0], hi_zero, STATUS_ADDR) ? status_word
		: hit(haddr[7:0], hi_zero, POWER_STATUS_ADDR) ? pstat_word
		: hit(haddr[7:0], hi_zero, RETAINED_ADDR) ? keep_q
		: hit(haddr[7:0], hi_zero, SCRATCH_ADDR) ? scratch_q
		: 32'h0000_0000;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			waddr_q <= 8'h00;
			whi_q <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_q <= take && hwrite;
			if (take) waddr_q <= haddr[7:0];
			if (take) whi_q <= hi_zero;
			if (rd_take) hrdata <= rd_word;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_left_bor;
		(state_q == SEQ_BOR_HOLD) && !bor_low && !por_evt;
	endsequence

	property p_bor_then_powerup_timer;
		@(posedge hclk) disable iff (!hresetn)
		s_left_bor |=> (state_q == SEQ_POWERUP_TIMER) && !core_reset_n;
	endproperty
	a_bor_then_powerup_timer: assert property (p_bor_then_powerup_timer)
		else $error("brown-out release did not start the power-up delay");

	property p_hold_in_powerup_timer;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == SEQ_POWERUP_TIMER) |-> !core_reset_n;
	endproperty
	a_hold_in_powerup_timer: assert property (p_hold_in_powerup_timer)
		else $error("core released during the power-up delay");

	property p_wake_keeps_regs;
		@(posedge hclk) disable iff (!hresetn)
		(wdt_wake_evt && !master_clear_n_low && !por_evt && !bor_evt && core_reset_n) |=> core_reset_n;
	endproperty
	a_wake_keeps_regs: assert property (p_wake_keeps_regs)
		else $error("watchdog wake-up reset the core");

	property p_por_flags;
		@(posedge hclk) disable iff (!hresetn)
		por_evt |=> timeout_flag_q && powerdown_flag_q && !por_stat_q
			&& (cause_q == CAUSE_POWER_ON);
	endproperty
	a_por_flags: assert property (p_por_flags)
		else $error("power-on flags wrong");

	property p_wdt_flags;
		@(posedge hclk) disable iff (!hresetn)
		(wdt_rst_evt && !por_evt && !bor_evt && !master_clear_n_evt) |=> !timeout_flag_q
			&& powerdown_flag_q ##1 core_reset_n || master_clear_n_low;
	endproperty
	a_wdt_flags: assert property (p_wdt_flags)
		else $error("watchdog reset flags or release wrong");

	property p_forced_powerup_timer;
		@(posedge hclk) disable iff (!hresetn)
		(por_evt && boren) |=> (state_q == SEQ_POWERUP_TIMER);
	endproperty
	a_forced_powerup_timer: assert property (p_forced_powerup_timer)
		else $error("brown-out enabled but power-up delay skipped");

	property p_no_timers;
		@(posedge hclk) disable iff (!hresetn)
		(por_evt && powerup_delay_enable_n_n && !boren && !crystal) |=> (state_q == SEQ_RUN);
	endproperty
	a_no_timers: assert property (p_no_timers)
		else $error("power-up delay ran while disabled");

	property p_ost_end;
		@(posedge hclk) disable iff (!hresetn)
		ost_done && !por_evt && !bor_evt |=> (state_q == SEQ_RUN)
			&& ($past(ost_cnt_q) == OST_W'(OST_CYCLES - 1));
	endproperty
	a_ost_end: assert property (p_ost_end)
		else $error("start-up count ended at the wrong count");

	property p_bor_abort;
		@(posedge hclk) disable iff (!hresetn)
		((state_q == SEQ_POWERUP_TIMER) && bor_evt) |=> (state_q == SEQ_BOR_HOLD) && (powerup_timer_cnt_q == '0);
	endproperty
	a_bor_abort: assert property (p_bor_abort)
		else $error("dip during power-up delay did not abort it");

	property p_master_clear_n_release;
		@(posedge hclk) disable iff (!hresetn)
		($rose(master_clear_n_f.level) && (state_q == SEQ_RUN) && (state_d == SEQ_RUN)
			&& !wdt_rst_evt) |=> core_reset_n;
	endproperty
	a_master_clear_n_release: assert property (p_master_clear_n_release)
		else $error("release of master clear did not start execution");

	property p_bor_disabled;
		@(posedge hclk) disable iff (!hresetn)
		(!boren && (state_q != SEQ_BOR_HOLD)) |=> (state_q != SEQ_BOR_HOLD);
	endproperty
	a_bor_disabled: assert property (p_bor_disabled)
		else $error("brown-out reset while disabled");
endmodule : reset_timeout_sequencer
`default_nettype wire

// ==== osc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module osc_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// oscillator pins
	output logic rc_osc_clk,
	output logic osc_input_pin
);
	logic [2:0] div_q;
	// divide by 8 keeps both clocks well below the hclk/4 sampling limit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) div_q <= 3'h0;
		else div_q <= div_q + 3'h1;
	end
	assign rc_osc_clk = div_q[2];
	assign osc_input_pin = div_q[2];
endmodule : osc_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import reset_seq_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic supply_rise_det = 1'b0;
	logic brownout_detect = 1'b0;
	logic master_clear_n = 1'b1;
	logic cpu_asleep = 1'b0;
	logic watchdog_timeout = 1'b0;
	logic watchdog_clear = 1'b0;
	logic sleep_cmd = 1'b0;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic hready, osc_input_pin, rc_osc_clk, core_reset_n, core_hold, watchdog_wake;
	int errors = 0;
	int check_count = 0;
	int wakes = 0;
	always #25 hclk = ~hclk;
	always @(posedge hclk) if (watchdog_wake === 1'b1) wakes++;
	osc_model u_osc (.hclk, .hresetn, .rc_osc_clk, .osc_input_pin);
	reset_timeout_sequencer #(.MASTER_CLEAR_N_FILTER_CYCLES(3), .BOR_FILTER_CYCLES(5), .POWERUP_TIMER_TICKS(4),
		.OST_CYCLES(1024)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout(hready), .hresp(), .supply_rise_det,
		.brownout_detect, .master_clear_n, .osc_input_pin, .rc_osc_clk, .cpu_asleep,
		.watchdog_timeout, .watchdog_clear, .sleep_cmd, .core_reset_n, .core_hold,
		.watchdog_wake);
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task automatic pon;
		supply_rise_det <= 1'b0;
		cyc(5);
		supply_rise_det <= 1'b1;
	endtask : pon
	task automatic dip(input int n);
		brownout_detect <= 1'b1;
		cyc(n);
		brownout_detect <= 1'b0;
	endtask : dip
	task automatic clr(input int n);
		master_clear_n <= 1'b0;
		cyc(n);
		master_clear_n <= 1'b1;
	endtask : clr
	task automatic wd_pulse;
		watchdog_timeout <= 1'b1;
		cyc(1);
		watchdog_timeout <= 1'b0;
		cyc(5);
	endtask : wd_pulse
	task automatic held(input logic e);
		chk("core_reset_n", {31'h0, core_reset_n}, {31'h0, e});
	endtask : held
	task automatic settle;
		int i;
		i = 0;
		while (!(core_reset_n === 1'b1 && core_hold === 1'b0) && i < 20000) begin
			@(posedge hclk);
			i++;
		end
		held(1'b1);
	endtask : settle
	// tp is {powerdown, timeout}; leaves power status in r
	task automatic stat(input reset_cause_t c, input logic [1:0] tp, input logic por);
		bus(1'b0, STATUS_ADDR, 32'h0);
		chk("cause", {29'h0, r[4:2]}, {29'h0, c});
		chk("to_pd", {30'h0, r[1:0]}, {30'h0, tp});
		bus(1'b0, POWER_STATUS_ADDR, 32'h0);
		chk("por", {31'h0, r[1]}, {31'h0, por});
	endtask : stat
	task automatic close_out;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		cyc(60000);
		errors++;
		close_out();
	end
	initial begin
		cyc(12);
		hresetn <= 1'b1;
		bus(1'b0, CONFIG_WORD_ADDR, 32'h0);
		chk("config", r, 32'h3fff);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", r, 32'h0);
		pon();
		cyc(12);
		held(1'b0);
		settle();
		stat(CAUSE_POWER_ON, 2'b11, 1'b0);
		bus(1'b1, POWER_STATUS_ADDR, 32'h3);
		bus(1'b1, RETAINED_ADDR, 32'ha5a5_0f0f);
		bus(1'b1, SCRATCH_ADDR, 32'h1234);
		clr(2);
		cyc(30);
		bus(1'b0, SCRATCH_ADDR, 32'h0);
		chk("short clear", r, 32'h1234);
		dip(20);
		cyc(15);
		dip(20);
		cyc(20);
		held(1'b0);
		settle();
		stat(CAUSE_BROWNOUT, 2'b11, 1'b1);
		chk("bor", {31'h0, r[0]}, 32'h0);
		bus(1'b0, SCRATCH_ADDR, 32'h0);
		chk("scratch", r, 32'h0);
		bus(1'b0, RETAINED_ADDR, 32'h0);
		chk("retained", r, 32'ha5a5_0f0f);
		wd_pulse();
		stat(CAUSE_WDT_RESET, 2'b10, 1'b1);
		clr(30);
		settle();
		stat(CAUSE_MASTER_CLEAR_N_RUN, 2'b10, 1'b1);
		cpu_asleep <= 1'b1;
		clr(30);
		cpu_asleep <= 1'b0;
		settle();
		stat(CAUSE_MASTER_CLEAR_N_SLEEP, 2'b01, 1'b1);
		bus(1'b1, SCRATCH_ADDR, 32'h55);
		cpu_asleep <= 1'b1;
		wd_pulse();
		cpu_asleep <= 1'b0;
		chk("wake pulses", wakes, 32'h1);
		held(1'b1);
		stat(CAUSE_WDT_WAKE, 2'b00, 1'b1);
		bus(1'b0, SCRATCH_ADDR, 32'h0);
		chk("scratch kept", r, 32'h55);
		watchdog_clear <= 1'b1;
		cyc(1);
		watchdog_clear <= 1'b0;
		stat(CAUSE_WDT_WAKE, 2'b11, 1'b1);
		sleep_cmd <= 1'b1;
		cyc(1);
		sleep_cmd <= 1'b0;
		stat(CAUSE_WDT_WAKE, 2'b01, 1'b1);
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, CONFIG_WORD_ADDR, 32'h3fbc | m);
			pon();
			cyc(7000);
			held(1'b0);
			settle();
		end
		// wake-up in a crystal mode runs the start-up count without resetting the core
		bus(1'b1, SCRATCH_ADDR, 32'h99);
		cpu_asleep <= 1'b1;
		wd_pulse();
		cpu_asleep <= 1'b0;
		held(1'b1);
		chk("wake hold", {31'h0, core_hold}, 32'h1);
		settle();
		chk("wake pulses crystal", wakes, 32'h2);
		bus(1'b0, SCRATCH_ADDR, 32'h0);
		chk("scratch after wake", r, 32'h99);
		master_clear_n <= 1'b0;
		pon();
		cyc(9000);
		held(1'b0);
		master_clear_n <= 1'b1;
		cyc(10);
		held(1'b1);
		bus(1'b1, CONFIG_WORD_ADDR, 32'h3fbf);
		bus(1'b1, SCRATCH_ADDR, 32'h77);
		dip(20);
		cyc(5);
		bus(1'b0, SCRATCH_ADDR, 32'h0);
		chk("no brownout", r, 32'h77);
		pon();
		cyc(15);
		held(1'b1);
		stat(CAUSE_POWER_ON, 2'b11, 1'b0);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
